//--- logic/capture_channel_modes.sv
// Capture channel mode logic with Wishbone register access
// Behaviour
// - Mode 0100: rise to capture, fall to shadow
// - Mode 0101: rise moves shadow, loads timer
// - Mode 0110: same transfer on falling edge
// - Mode 0111: same transfer on every edge
// - Hall mode: channel 0 captures, others compare
// - Valid hall event captures timer, resets timer
// - Hall edge starts filter, sample at one
// - Mode 1001: position fall clears state bit
// - Mode 1010: input rise, position fall
// - Mode 1011: input fall, position rise
// - Mode 1100: input rise, position rise
// - Mode 1101: input fall, position fall
// - Mode 1110: any input, any position edge
// - Mode 1111 does nothing
// - Position source: pin, latch, else one
// - Select upper two bits read zero
// - Disable request bit two, default zero
// - Disable status bit two set when off
// - Capture-mode input edges set status flags
// - Position event sets channel state bit
`timescale 1ns/1ns
`default_nettype none
module capture_channel_modes
	import capture_pkg::*;
#(
	parameter int TW = TIMER_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] chan_pin_i,
	input wire logic [2:0] pos_pin_i,
	input wire logic [2:0] pos_latch_i,
	input wire logic [2:0] compare_event_i,
	input wire logic [TW-1:0] main_timer_i,
	output logic main_timer_reset_o,
	output logic [2:0] chan_state_o,
	output logic [2:0] compare_en_o,
	output logic unit_clk_en_o
);
	// ------------------------------------------------------------
	// Registers and helpers
	// ------------------------------------------------------------
	logic [11:0] mode_q;
	logic [POS_SEL_W-1:0] pos_sel_q;
	logic dis_req_q;
	logic dis_state_q;
	unit_state_t unit_q;
	logic [2:0] chan_flag_q;
	logic [2:0] state_q;
	logic [TW-1:0] cap_q [CHANNELS];
	logic [TW-1:0] shd_q [CHANNELS];
	logic [5:0] dt_q;
	logic [2:0] hall_last_q;
	logic hall_event_q;
	logic [2:0] pos_src;
	logic [2:0] ch_sel_mask;
	logic [2:0] pos_sel_mask;
	logic [31:0] rd_data;
	logic wr_stb;
	logic rd_stb;
	logic running;
	logic all_hall;

	function automatic chan_mode_t mode_of(input logic [11:0] m, input int n);
		return chan_mode_t'(m[4*n +: 4]);
	endfunction : mode_of

	function automatic logic is_capture(input chan_mode_t m);
		return (m[2] | m[3]) & (m != MODE_RSVD) & (m != MODE_HYST);
	endfunction : is_capture

	// Input sources selected before synchronisation
	always_comb
	begin
		for (int n = 0; n < CHANNELS; n++)
		begin
			unique case (pos_sel_q[2*n +: 2])
				SRC_PIN: pos_src[n] = pos_pin_i[n];
				SRC_LATCH: pos_src[n] = pos_latch_i[n];
				default: pos_src[n] = 1'b1;
			endcase
		end
	end

	edge_if #(.N(6)) edges ();
	edge_sync #(.N(6)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({pos_src, chan_pin_i}),
		.edges(edges)
	);

	wire logic [2:0] ch_r = edges.rise[2:0];
	wire logic [2:0] ch_f = edges.fall[2:0];
	wire logic [2:0] ps_r = edges.rise[5:3];
	wire logic [2:0] ps_f = edges.fall[5:3];
	wire logic [2:0] ps_lvl = edges.level[5:3];

	assign running = (unit_q == UNIT_RUN);
	assign all_hall = (mode_of(mode_q, 0) == MODE_HALL) && (mode_of(mode_q, 1) == MODE_HALL)
		&& (mode_of(mode_q, 2) == MODE_HALL);

	// ------------------------------------------------------------
	// Capture data path
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int n = 0; n < CHANNELS; n++)
			begin
				cap_q[n] <= '0;
				shd_q[n] <= '0;
			end
		end
		else if (running)
		begin
			for (int n = 0; n < CHANNELS; n++)
			begin
				unique case (mode_of(mode_q, n))
					MODE_DBL_SPLIT:
					begin
						if (ch_r[n])
							cap_q[n] <= main_timer_i;
						if (ch_f[n])
							shd_q[n] <= main_timer_i;
					end
					MODE_DBL_RISE, MODE_DBL_FALL, MODE_DBL_ANY:
					begin
						if (ch_sel_mask[n])
						begin
							cap_q[n] <= shd_q[n];
							shd_q[n] <= main_timer_i;
						end
					end
					MODE_HALL:
					begin
						if (n == 0 && hall_event_q)
							cap_q[n] <= main_timer_i;
					end
					MODE_MI_RF, MODE_MI_FR, MODE_MI_RR, MODE_MI_FF, MODE_MI_AA:
					begin
						if (ch_sel_mask[n])
							cap_q[n] <= main_timer_i;
						if (pos_sel_mask[n])
							shd_q[n] <= main_timer_i;
					end
					default:
					begin
						// Compare, hysteresis and reserved codes capture nothing
					end
				endcase
			end
		end
	end

	// Edge selection per mode
	always_comb
	begin
		for (int n = 0; n < CHANNELS; n++)
		begin
			unique case (mode_of(mode_q, n))
				MODE_DBL_RISE, MODE_MI_RF, MODE_MI_RR: ch_sel_mask[n] = ch_r[n];
				MODE_DBL_FALL, MODE_MI_FR, MODE_MI_FF: ch_sel_mask[n] = ch_f[n];
				MODE_DBL_ANY, MODE_MI_AA: ch_sel_mask[n] = ch_r[n] | ch_f[n];
				default: ch_sel_mask[n] = 1'b0;
			endcase
			unique case (mode_of(mode_q, n))
				MODE_MI_RF, MODE_MI_FF: pos_sel_mask[n] = ps_f[n];
				MODE_MI_FR, MODE_MI_RR: pos_sel_mask[n] = ps_r[n];
				MODE_MI_AA: pos_sel_mask[n] = ps_r[n] | ps_f[n];
				default: pos_sel_mask[n] = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Hall filter
	// ------------------------------------------------------------
	// The pattern is sampled late so that sensor bounce settles first
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dt_q <= DT_IDLE;
			hall_last_q <= '0;
			hall_event_q <= 1'b0;
		end
		else
		begin
			hall_event_q <= 1'b0;
			if (running && all_hall)
			begin
				if (|(edges.rise[5:3] | edges.fall[5:3]))
					dt_q <= DT_START;
				else if (dt_q != DT_IDLE)
					dt_q <= dt_q - 6'h01;
				if (dt_q == DT_SAMPLE)
				begin
					hall_last_q <= ps_lvl;
					hall_event_q <= (ps_lvl != hall_last_q);
				end
			end
			else
				dt_q <= DT_IDLE;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			main_timer_reset_o <= 1'b0;
		else
			main_timer_reset_o <= running && all_hall && hall_event_q;
	end

	// ------------------------------------------------------------
	// Flags and state bits
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			chan_flag_q <= '0;
		else
		begin
			for (int n = 0; n < CHANNELS; n++)
			begin
				// Set wins over a clear in the same cycle
				if (running && is_capture(mode_of(mode_q, n)) && (ch_r[n] | ch_f[n]))
					chan_flag_q[n] <= 1'b1;
				else if (wr_stb && wb_adr_i[5:2] == ADDR_STATUS && wb_sel_i[0] && wb_dat_i[n])
					chan_flag_q[n] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_q <= '0;
		else
		begin
			for (int n = 0; n < CHANNELS; n++)
			begin
				if (running && mode_of(mode_q, n) == MODE_HYST && ps_f[n])
					state_q[n] <= 1'b0;
				else if (running && mode_of(mode_q, n) == MODE_HYST && ps_lvl[n]
					&& compare_event_i[n])
					state_q[n] <= 1'b1;
				else if (running && pos_sel_mask[n])
					state_q[n] <= 1'b1;
				else if (wr_stb && wb_adr_i[5:2] == ADDR_STATUS && wb_sel_i[0]
					&& wb_dat_i[n + 4])
					state_q[n] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			chan_state_o <= '0;
			compare_en_o <= '0;
		end
		else
		begin
			chan_state_o <= state_q;
			for (int n = 0; n < CHANNELS; n++)
				compare_en_o[n] <= running && (mode_of(mode_q, n) <= MODE_CMP_AB
					&& mode_of(mode_q, n) != MODE_OFF
					|| mode_of(mode_q, n) == MODE_HYST
					|| (mode_of(mode_q, n) == MODE_HALL && n != 0));
		end
	end

	// ------------------------------------------------------------
	// Disable handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			unit_q <= UNIT_RUN;
		else
		begin
			unique case (unit_q)
				UNIT_RUN:
					if (dis_req_q)
						unit_q <= UNIT_DRAIN;
				UNIT_DRAIN:
					if (!dis_req_q)
						unit_q <= UNIT_RUN;
					else if (dt_q == DT_IDLE && !hall_event_q)
						unit_q <= UNIT_OFF;
				UNIT_OFF:
					if (!dis_req_q)
						unit_q <= UNIT_RUN;
				default:
					unit_q <= UNIT_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dis_state_q <= 1'b0;
			unit_clk_en_o <= 1'b1;
		end
		else
		begin
			dis_state_q <= (unit_q == UNIT_OFF);
			unit_clk_en_o <= (unit_q != UNIT_OFF);
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_q <= MODE_RESET;
			pos_sel_q <= POS_SEL_RESET[POS_SEL_W-1:0];
			dis_req_q <= 1'b0;
		end
		else if (wr_stb)
		begin
			unique case (wb_adr_i[5:2])
				ADDR_MODE:
				begin
					if (wb_sel_i[0])
						mode_q[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						mode_q[11:8] <= wb_dat_i[11:8];
				end
				ADDR_POS_SEL:
					if (wb_sel_i[0])
						pos_sel_q <= wb_dat_i[POS_SEL_W-1:0];
				ADDR_DIS_CTRL:
					if (wb_sel_i[0])
						dis_req_q <= wb_dat_i[DIS_BIT];
				default:
				begin
				end
			endcase
		end
	end

	always_comb
	begin
		rd_data = '0;
		unique case (wb_adr_i[5:2])
			ADDR_MODE: rd_data[11:0] = mode_q;
			ADDR_POS_SEL: rd_data[POS_SEL_W-1:0] = pos_sel_q;
			ADDR_DIS_CTRL: rd_data[DIS_BIT] = dis_req_q;
			ADDR_DIS_STATE: rd_data[DIS_BIT] = dis_state_q;
			ADDR_STATUS: rd_data[6:0] = {state_q, 1'b0, chan_flag_q};
			ADDR_TIMER: rd_data[TW-1:0] = main_timer_i;
			ADDR_CAP0, ADDR_CAP0 + 4'h1, ADDR_CAP0 + 4'h2:
				rd_data[TW-1:0] = cap_q[wb_adr_i[3:2]];
			ADDR_SHD0, ADDR_SHD0 + 4'h1, ADDR_SHD0 + 4'h2:
				rd_data[TW-1:0] = shd_q[wb_adr_i[3:2]];
			default: rd_data = '0;
		endcase
	end

	// Single-cycle answer; unmapped addresses ack with zero data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= wr_stb || rd_stb;
			if (rd_stb)
				wb_dat_o <= rd_data;
		end
	end
endmodule : capture_channel_modes
`default_nettype wire

//--- logic/capture_pkg.sv
// Package with register map, mode codes and field layout of the capture unit
package capture_pkg;
	localparam int TIMER_W = 16;
	localparam int CHANNELS = 3;
	// ------------------------------------------------------------
	// Register word addresses (byte address bits [5:2])
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_POS_SEL = 4'h1;
	localparam logic [3:0] ADDR_DIS_CTRL = 4'h2;
	localparam logic [3:0] ADDR_DIS_STATE = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_CAP0 = 4'h8;
	localparam logic [3:0] ADDR_SHD0 = 4'hc;
	localparam logic [3:0] ADDR_TIMER = 4'h5;
	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int DIS_BIT = 2;
	localparam int POS_SEL_W = 6;
	localparam logic [11:0] MODE_RESET = 12'h000;
	localparam logic [7:0] POS_SEL_RESET = 8'h00;
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_LATCH = 2'h1;
	localparam logic [5:0] DT_START = 6'h03;
	localparam logic [5:0] DT_SAMPLE = 6'h01;
	localparam logic [5:0] DT_IDLE = 6'h00;
	// ------------------------------------------------------------
	// Channel modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_OFF = 4'b0000,
		MODE_CMP_A = 4'b0001,
		MODE_CMP_B = 4'b0010,
		MODE_CMP_AB = 4'b0011,
		MODE_DBL_SPLIT = 4'b0100,
		MODE_DBL_RISE = 4'b0101,
		MODE_DBL_FALL = 4'b0110,
		MODE_DBL_ANY = 4'b0111,
		MODE_HALL = 4'b1000,
		MODE_HYST = 4'b1001,
		MODE_MI_RF = 4'b1010,
		MODE_MI_FR = 4'b1011,
		MODE_MI_RR = 4'b1100,
		MODE_MI_FF = 4'b1101,
		MODE_MI_AA = 4'b1110,
		MODE_RSVD = 4'b1111
	} chan_mode_t;
	typedef enum logic [1:0] {
		UNIT_RUN = 2'b00,
		UNIT_DRAIN = 2'b01,
		UNIT_OFF = 2'b10
	} unit_state_t;
endpackage : capture_pkg

//--- logic/edge_if.sv
// Interface carrying synchronised levels and edge pulses between modules
`timescale 1ns/1ns
`default_nettype none
interface edge_if #(parameter int N = 6);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport src (output level, rise, fall);
	modport dst (input level, rise, fall);
endinterface : edge_if
`default_nettype wire

//--- logic/edge_sync.sv
// Two-flop synchroniser with edge detection for the capture inputs
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
	parameter int N = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [N-1:0] async_i,
	edge_if.src edges
);
	logic [N-1:0] meta_q;
	logic [N-1:0] sync_q;
	logic [N-1:0] last_q;
	// First stage feeds the second stage only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	assign edges.level = sync_q;
	assign edges.rise = sync_q & ~last_q;
	assign edges.fall = ~sync_q & last_q;
endmodule : edge_sync
`default_nettype wire

//--- test/sensor_model.sv
// Sensor model driving the channel and position pins
`timescale 1ns/1ns
`default_nettype none
module sensor_model (
	input wire logic clk_i,
	input wire logic [2:0] chan_lvl_i,
	input wire logic [2:0] pos_lvl_i,
	output logic [2:0] chan_pin_o,
	output logic [2:0] pos_pin_o
);
	initial chan_pin_o = 3'h0;
	initial pos_pin_o = 3'h0;
	// Pins move just after an edge, as from a board clocked off the same source
	always @(posedge clk_i)
	begin
		chan_pin_o <= chan_lvl_i;
		pos_pin_o <= pos_lvl_i;
	end
endmodule : sensor_model
`default_nettype wire

//--- test/capture_monitor.sv
// Port checker for the capture channel block
`timescale 1ns/1ns
`default_nettype none
module capture_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic main_timer_reset_o,
	input wire logic [2:0] chan_state_o,
	input wire logic [2:0] compare_en_o,
	input wire logic unit_clk_en_o
);
	logic [3:0] since_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Cycles since the last ack; gating may only move shortly after a write
	always_ff @(posedge clk_i)
		if (rst_i)
			since_q <= 4'hf;
		else if (wb_ack_o)
			since_q <= 4'h0;
		else if (since_q != 4'hf)
			since_q <= since_q + 4'h1;
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_timer_reset_pulse: assert property (main_timer_reset_o |=> !main_timer_reset_o)
		else $error("timer reset not a pulse");
	a_hall_roles: assert property (main_timer_reset_o |-> compare_en_o == 3'h6)
		else $error("hall event outside hall roles");
	a_reset_running: assert property ($fell(rst_i) |-> unit_clk_en_o && chan_state_o == 3'h0)
		else $error("unit not running after reset");
	a_off_frozen: assert property (!unit_clk_en_o && !wb_cyc_i |=> $stable(chan_state_o))
		else $error("state moved while unit off");
	a_gate_after_write: assert property ($changed(unit_clk_en_o) |-> since_q < 4'h8)
		else $error("clock gating changed without a write");
	c_hall: cover property (main_timer_reset_o);
	c_off: cover property ($fell(unit_clk_en_o));
	c_state: cover property ($rose(chan_state_o[0]));
endmodule : capture_monitor
bind capture_channel_modes capture_monitor i_capture_monitor (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .main_timer_reset_o, .chan_state_o, .compare_en_o, .unit_clk_en_o);
`default_nettype wire

//--- test/tb_top.sv
// Testbench for the capture channel modes block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import capture_pkg::*;
	localparam logic [4:0] CR = 5'h15;
	localparam logic [4:0] CF = 5'h1a;
	localparam logic [4:0] PR = 5'h16;
	localparam logic [4:0] PF = 5'h19;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0;
	logic [2:0] cl = 3'h0;
	logic [2:0] pl = 3'h0;
	logic [2:0] latch = 3'h0;
	logic [2:0] cev = 3'h0;
	logic [15:0] tmr = 16'h0;
	logic [31:0] rdat;
	logic ack;
	logic [2:0] cpin;
	logic [2:0] ppin;
	logic trst;
	logic [2:0] st;
	logic [2:0] cen;
	logic uen;
	logic [3:0] ml [10] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	logic [3:0] m;
	logic [15:0] ec = 16'h0;
	logic [15:0] es = 16'h0;
	logic [31:0] q;
	logic ef = 1'b0;
	logic sb = 1'b0;
	logic off = 1'b0;
	int miscompares = 0;
	int n_checks = 0;
	always #20 clk_i = ~clk_i;
	sensor_model i_sensor_model (.clk_i, .chan_lvl_i(cl), .pos_lvl_i(pl), .chan_pin_o(cpin),
		.pos_pin_o(ppin));
	capture_channel_modes i_capture_channel_modes (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .chan_pin_i(cpin), .pos_pin_i(ppin), .pos_latch_i(latch),
		.compare_event_i(cev), .main_timer_i(tmr), .main_timer_reset_o(trst), .chan_state_o(st),
		.compare_en_o(cen), .unit_clk_en_o(uen));
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
		chk({31'h0, ack}, 32'h1, "bus answer");
		if (ack !== 1'b1)
			conclude();
	endtask : wb
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
		wb(1'b0, a, 32'h0);
		chk(q, e, s);
	endtask : rd
	// Moves one pin of channel 0 and predicts capture, shadow, flag and state
	task automatic mv(input logic p, input logic l);
		logic o;
		logic r;
		logic f;
		logic mi;
		tmr <= tmr + 16'h0111;
		@(posedge clk_i);
		o = p ? pl[0] : cl[0];
		r = l & ~o;
		f = o & ~l;
		mi = m inside {[4'ha:4'he]};
		if (p)
			pl[0] <= l;
		else
			cl[0] <= l;
		repeat (6) @(posedge clk_i);
		if (!off && (r || f) && !p)
		begin
			ef = m inside {[4'h4:4'he]} ? 1'b1 : ef;
			if (mi && (r ? CR[m - 4'ha] : CF[m - 4'ha]))
				ec = tmr;
			if (m == 4'h4 && r)
				ec = tmr;
			if (m == 4'h4 && f)
				es = tmr;
			if (m == 4'h7 || (m == 4'h5 && r) || (m == 4'h6 && f))
			begin
				ec = es;
				es = tmr;
			end
		end
		if (!off && p && mi && (r ? PR[m - 4'ha] : (f && PF[m - 4'ha])))
		begin
			es = tmr;
			sb = 1'b1;
		end
		rd(ADDR_CAP0, {16'h0, ec}, "capture");
		if (!$isunknown(es))
			rd(ADDR_SHD0, {16'h0, es}, "shadow");
		rd(ADDR_STATUS, {25'h0, 2'b00, sb, 3'b000, ef}, "status");
	endtask : mv
	task automatic wait_en(input logic v);
		for (int n = 0; n < 30 && uen !== v; n++)
			@(posedge clk_i);
		chk({31'h0, uen}, {31'h0, v}, "clock enable");
		if (uen !== v)
			conclude();
	endtask : wait_en
	task automatic hall(input int e);
		int k;
		k = 0;
		repeat (20)
		begin
			@(posedge clk_i);
			k += (trst === 1'b1) ? 1 : 0;
		end
		chk(k, e, "timer reset pulses");
	endtask : hall
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rd(ADDR_POS_SEL, 32'h0, "select reset");
		rd(ADDR_DIS_CTRL, 32'h0, "request reset");
		rd(ADDR_DIS_STATE, 32'h0, "status reset");
		wr(ADDR_POS_SEL, 32'hff);
		rd(ADDR_POS_SEL, 32'h3f, "select upper bits");
		wr(ADDR_POS_SEL, 32'h0);
		rd(4'h7, 32'h0, "unmapped");
		$display("test registers done");
		foreach (ml[i])
		begin
			m = ml[i];
			wr(ADDR_MODE, {28'h0, m});
			wr(ADDR_STATUS, 32'h77);
			ef = 1'b0;
			sb = 1'b0;
			mv(1'b0, 1'b1);
			mv(1'b0, 1'b0);
			mv(1'b1, 1'b1);
			mv(1'b1, 1'b0);
		end
		$display("test capture modes done");
		m = 4'h4;
		wr(ADDR_MODE, 32'h4);
		wr(ADDR_STATUS, 32'h77);
		wr(ADDR_DIS_CTRL, 32'h4);
		wait_en(1'b0);
		rd(ADDR_DIS_STATE, 32'h4, "disabled");
		off = 1'b1;
		mv(1'b0, 1'b1);
		wr(ADDR_DIS_CTRL, 32'h0);
		wait_en(1'b1);
		rd(ADDR_DIS_STATE, 32'h0, "enabled");
		off = 1'b0;
		mv(1'b0, 1'b0);
		$display("test disable done");
		wr(ADDR_MODE, 32'h9);
		for (int s = 0; s < 3; s++)
		begin
			wr(ADDR_POS_SEL, 32'(s));
			latch[0] <= 1'b1;
			repeat (6) @(posedge clk_i);
			cev[0] <= 1'b1;
			@(posedge clk_i);
			cev[0] <= 1'b0;
			repeat (4) @(posedge clk_i);
			chk({29'h0, st}, {31'h0, s != 0}, "state set");
			latch[0] <= 1'b0;
			repeat (6) @(posedge clk_i);
			chk({29'h0, st}, {31'h0, s == 2}, "state cleared");
			wr(ADDR_STATUS, 32'h70);
		end
		wr(ADDR_POS_SEL, 32'h0);
		$display("test hysteresis done");
		wr(ADDR_MODE, 32'h888);
		// Roles are registered one cycle after the mode write lands
		@(posedge clk_i);
		chk({29'h0, cen}, 32'h6, "hall roles");
		tmr <= 16'h4321;
		pl[1] <= 1'b1;
		hall(1);
		rd(ADDR_CAP0, 32'h4321, "hall capture");
		pl[2] <= 1'b1;
		@(posedge clk_i);
		pl[2] <= 1'b0;
		hall(0);
		$display("test hall done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
